// ===== src/dbg_trace_defines.svh
`ifndef DBG_TRACE_DEFINES_SVH
`define DBG_TRACE_DEFINES_SVH

// ***************************************************************
// Pin synchroniser layout
// ***************************************************************
`define PIN_COUNT        5
`define PIN_BUS_HOLD     0
`define PIN_HALT         1
`define PIN_UNCOND       2
`define PIN_TRIG_IN      3
`define PIN_TRACE_DIS    4
`define PIN_RESET_VAL    5'h00

// ***************************************************************
// Timing counts
// ***************************************************************
`define BOOT_CYCLES      3'h4
`define BOOT_CNT_W       3

// ***************************************************************
// Field widths and positions
// ***************************************************************
`define WB_ADDR_W        30
`define EXEC_STATUS_W    2
`define TRACE_STATUS_W   4
`define TRIG_TYPE_W      11
`define TRIG_TYPE_UNCOND 10
`define TRACE_WORD_W     8
`define TRACE_TRIG_MARK  4'h8
`define TRACE_FIFO_DEPTH 32

`endif

// ===== src/dbg_trace_pkg.sv
package dbg_trace_pkg;

   // Core run state, one-hot
   typedef enum logic [3:0] {
      ST_BOOT = 4'h1,
      ST_RUN  = 4'h2,
      ST_WAIT = 4'h4,
      ST_HALT = 4'h8
   } run_state_e;

endpackage

// ===== src/trace_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module trace_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,       // Processor clock
   input  wire logic             reset_n,   // Async reset, active low
   input  wire logic [WIDTH-1:0] in_data,   // Word to store
   input  wire logic             in_valid,  // Word offered
   output logic                  in_ready,  // Room for a word
   output logic      [WIDTH-1:0] out_data,  // Oldest word
   output logic                  out_valid, // Oldest word present
   input  wire logic             out_ready  // Drain takes the word
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_q;
   logic [AW:0]      rd_ptr_q;
   logic             full;
   logic             empty;

   assign empty     = (wr_ptr_q == rd_ptr_q);
   assign full      = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_ptr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q <= '0;
      end else if (in_valid && !full) begin
         wr_ptr_q <= wr_ptr_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ptr_q <= '0;
      end else if (out_ready && !empty) begin
         rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

endmodule // trace_fifo

`default_nettype wire

// ===== src/debug_halt_and_trace_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_trace_defines.svh"

module debug_halt_and_trace_port #(
   parameter int FIFO_DEPTH = `TRACE_FIFO_DEPTH
) (
   input  wire logic                        clk,                // Processor clock
   input  wire logic                        reset_n,            // Async reset, active low
   // Debug pins
   input  wire logic                        bus_hold_ack_in,    // Outside master owns the bus
   input  wire logic                        halt_request_in,    // Debug halt request
   input  wire logic                        uncond_event_in,    // Unconditional debug event
   output logic                             wb_full_out,        // Writeback stage full
   output logic      [`WB_ADDR_W-1:0]       wb_instr_addr_out,  // Writeback instruction address
   output logic                             wb_complete_out,    // Writeback instruction completes
   output logic                             wait_enable_out,    // Wait enable bit
   output logic                             halt_ack_out,       // In debug halt
   // Trace pins
   output logic                             trigger_out,        // Trigger event strobe
   output logic      [`TRIG_TYPE_W-1:0]     trigger_type_out,   // Cause of the trigger
   output logic                             trace_cycle_strobe, // Trace cycle
   output logic      [`EXEC_STATUS_W-1:0]   first_cycle_exec_status,  // First cycle status
   output logic      [`EXEC_STATUS_W-1:0]   second_cycle_exec_status, // Second cycle status
   output logic      [`TRACE_STATUS_W-1:0]  trace_status_out,   // Trace status
   input  wire logic                        trigger_in,         // Returned trigger event
   input  wire logic                        trace_disable_in,   // Stop trace collection
   input  wire logic                        trace_sink_ready,   // Collector takes a trace cycle
   // Core side
   input  wire logic                        core_wb_valid,      // Writeback holds an instruction
   input  wire logic      [`WB_ADDR_W-1:0]  core_wb_addr,       // Its address
   input  wire logic                        core_wb_complete,   // It completes this cycle
   input  wire logic                        core_set_we,        // Software sets wait enable
   input  wire logic                        core_ext_irq,       // External interrupt
   input  wire logic                        core_timer_irq,     // Timer interrupt
   input  wire logic                        dbg_clear_we,       // Debugger clears wait enable
   input  wire logic                        scan_stop_cmd,      // Scan-port stop command pulse
   input  wire logic                        scan_resume_cmd,    // Scan-port resume pulse
   input  wire logic                        internal_debug_mode_bit, // Internal debug mode
   input  wire logic                        external_debug_mode_bit, // External debug mode
   input  wire logic [`TRIG_TYPE_UNCOND-1:0] core_debug_events, // Other debug events
   input  wire logic                        uncond_flag_clear,  // Software clears the flag
   input  wire logic                        debug_op_req,       // Debug operation request pulse
   input  wire logic [`EXEC_STATUS_W-1:0]   core_exec_status,   // Per-cycle exec status
   input  wire logic [`TRACE_STATUS_W-1:0]  core_trace_status,  // Per-cycle trace status
   input  wire logic                        trace_overflow_clear, // Clears overflow flag
   output logic                             core_run_enable,    // Core may fetch and execute
   output logic                             debug_irq_out,      // Debug interrupt pulse
   output logic                             uncond_event_flag,  // Status flag of the event
   output logic                             bus_held_out,       // Debug answers may be late
   output logic                             debug_op_done,      // Debug operation answered
   output logic                             trace_overflow_out  // Trace word was lost
);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [`PIN_COUNT-1:0] pins_raw;
   logic [`PIN_COUNT-1:0] sync1_q;
   logic [`PIN_COUNT-1:0] sync2_q;
   logic [`PIN_COUNT-1:0] sync3_q;
   logic [`PIN_COUNT-1:0] pin_q;

   assign pins_raw = {trace_disable_in, trigger_in, uncond_event_in,
                      halt_request_in, bus_hold_ack_in};

   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               sync3_q[gi] <= 1'b0;
               pin_q[gi]   <= 1'b0;
            end else begin
               sync1_q[gi] <= pins_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               // Glitch filter: only an agreed level counts
               if (sync2_q[gi] == sync3_q[gi]) begin
                  pin_q[gi] <= sync3_q[gi];
               end
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Halt sources and wait enable
   // ***************************************************************
   logic scan_stop_q;
   logic ude_stop_q;
   logic we_q;
   logic ude_prev_q;
   logic ude_rise;
   logic halt_cond;

   assign ude_rise  = pin_q[`PIN_UNCOND] && !ude_prev_q;
   assign halt_cond = pin_q[`PIN_HALT] || scan_stop_q || ude_stop_q;

   // Reset clears the scan command and the event stop; the pin is re-read after reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_stop_q <= 1'b0;
      end else if (scan_stop_cmd) begin
         scan_stop_q <= 1'b1;
      end else if (scan_resume_cmd) begin
         scan_stop_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ude_stop_q <= 1'b0;
      end else if (ude_rise && external_debug_mode_bit) begin
         ude_stop_q <= 1'b1;
      end else if (scan_resume_cmd) begin
         ude_stop_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         we_q <= 1'b0;
      end else if (core_set_we) begin
         we_q <= 1'b1;
      end else if (core_ext_irq || core_timer_irq || dbg_clear_we) begin
         we_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Run state machine
   // ***************************************************************
   dbg_trace_pkg::run_state_e state_q;
   dbg_trace_pkg::run_state_e state_d;
   logic [`BOOT_CNT_W-1:0]    boot_cnt_q;
   logic                      boot_done;

   assign boot_done = (boot_cnt_q == `BOOT_CYCLES);

   // Holds the core until the halt pin has crossed the synchroniser
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         boot_cnt_q <= '0;
      end else if (!boot_done) begin
         boot_cnt_q <= boot_cnt_q + 1'b1;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         dbg_trace_pkg::ST_BOOT: begin
            if (boot_done) begin
               if (halt_cond) begin
                  state_d = dbg_trace_pkg::ST_HALT;
               end else if (we_q) begin
                  state_d = dbg_trace_pkg::ST_WAIT;
               end else begin
                  state_d = dbg_trace_pkg::ST_RUN;
               end
            end
         end
         dbg_trace_pkg::ST_RUN: begin
            if (halt_cond) begin
               state_d = dbg_trace_pkg::ST_HALT;
            end else if (we_q) begin
               state_d = dbg_trace_pkg::ST_WAIT;
            end
         end
         dbg_trace_pkg::ST_WAIT: begin
            if (halt_cond) begin
               state_d = dbg_trace_pkg::ST_HALT;
            end else if (!we_q) begin
               state_d = dbg_trace_pkg::ST_RUN;
            end
         end
         dbg_trace_pkg::ST_HALT: begin
            if (!halt_cond) begin
               state_d = we_q ? dbg_trace_pkg::ST_WAIT : dbg_trace_pkg::ST_RUN;
            end
         end
         default: begin
            state_d = dbg_trace_pkg::ST_BOOT;
         end
      endcase
   end

   // No clock gate anywhere: halt only withdraws the run enable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q         <= dbg_trace_pkg::ST_BOOT;
         core_run_enable <= 1'b0;
         halt_ack_out    <= 1'b0;
         wait_enable_out <= 1'b0;
      end else begin
         state_q         <= state_d;
         core_run_enable <= (state_d == dbg_trace_pkg::ST_RUN);
         halt_ack_out    <= (state_d == dbg_trace_pkg::ST_HALT);
         wait_enable_out <= we_q;
      end
   end

   // ***************************************************************
   // Unconditional event, triggers, bus hold
   // ***************************************************************
   logic [`TRIG_TYPE_W-1:0] trig_ev;
   logic                    trig_fire;
   logic                    op_pending_q;

   assign trig_ev   = {ude_rise, core_debug_events};
   assign trig_fire = !internal_debug_mode_bit && !external_debug_mode_bit && (|trig_ev);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ude_prev_q        <= 1'b0;
         uncond_event_flag <= 1'b0;
         debug_irq_out     <= 1'b0;
      end else begin
         ude_prev_q    <= pin_q[`PIN_UNCOND];
         debug_irq_out <= ude_rise && internal_debug_mode_bit;
         // Set wins over a clear in the same cycle
         if (pin_q[`PIN_UNCOND]) begin
            uncond_event_flag <= 1'b1;
         end else if (uncond_flag_clear) begin
            uncond_event_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trigger_out      <= 1'b0;
         trigger_type_out <= '0;
      end else begin
         trigger_out      <= trig_fire;
         trigger_type_out <= trig_fire ? trig_ev : '0;
      end
   end

   // Debug operations wait while another master may own the bus
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_pending_q  <= 1'b0;
         debug_op_done <= 1'b0;
         bus_held_out  <= 1'b0;
      end else begin
         bus_held_out  <= pin_q[`PIN_BUS_HOLD];
         debug_op_done <= op_pending_q && !pin_q[`PIN_BUS_HOLD];
         if (debug_op_req) begin
            op_pending_q <= 1'b1;
         end else if (!pin_q[`PIN_BUS_HOLD]) begin
            op_pending_q <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Writeback reporting
   // ***************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_full_out       <= 1'b0;
         wb_complete_out   <= 1'b0;
         wb_instr_addr_out <= '0;
      end else begin
         wb_full_out     <= core_wb_valid;
         wb_complete_out <= core_wb_valid && core_wb_complete;
         if (core_wb_valid) begin
            wb_instr_addr_out <= core_wb_addr;
         end
      end
   end

   // ***************************************************************
   // Trace collection and broadcast
   // ***************************************************************
   logic                        phase_q;
   logic                        collect_q;
   logic [`EXEC_STATUS_W-1:0]   first_es_q;
   logic [`TRACE_STATUS_W-1:0]  ts_acc_q;
   logic                        trig_seen_q;
   logic [`TRACE_STATUS_W-1:0]  ts_pair;
   logic [`TRACE_WORD_W-1:0]    push_word;
   logic                        push_valid;
   logic                        push_ready;
   logic [`TRACE_WORD_W-1:0]    pop_word;
   logic                        pop_valid;
   logic                        pop_ready;

   assign ts_pair    = ts_acc_q | core_trace_status
                       | ((trig_seen_q || pin_q[`PIN_TRIG_IN]) ? `TRACE_TRIG_MARK : 4'h0);
   assign push_word  = {first_es_q, core_exec_status, ts_pair};
   assign push_valid = phase_q && collect_q;
   assign pop_ready  = phase_q && trace_sink_ready;

   // Collection is sampled at the start of a pair, so a pair never splits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q     <= 1'b0;
         collect_q   <= 1'b0;
         first_es_q  <= '0;
         ts_acc_q    <= '0;
         trig_seen_q <= 1'b0;
      end else begin
         phase_q <= !phase_q;
         if (!phase_q) begin
            collect_q   <= !pin_q[`PIN_TRACE_DIS];
            first_es_q  <= core_exec_status;
            ts_acc_q    <= core_trace_status;
            trig_seen_q <= pin_q[`PIN_TRIG_IN];
         end
      end
   end

   // Trace must not stall the core, so a full buffer drops and flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trace_overflow_out <= 1'b0;
      end else if (push_valid && !push_ready) begin
         trace_overflow_out <= 1'b1;
      end else if (trace_overflow_clear) begin
         trace_overflow_out <= 1'b0;
      end
   end

   trace_fifo #(
      .WIDTH (`TRACE_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_trace_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_data   (push_word),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .out_data  (pop_word),
      .out_valid (pop_valid),
      .out_ready (pop_ready)
   );

   // Buffered words still drain after disable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trace_cycle_strobe       <= 1'b0;
         first_cycle_exec_status  <= '0;
         second_cycle_exec_status <= '0;
         trace_status_out         <= '0;
      end else begin
         trace_cycle_strobe <= pop_ready && pop_valid;
         if (pop_ready && pop_valid) begin
            first_cycle_exec_status  <= pop_word[7:6];
            second_cycle_exec_status <= pop_word[5:4];
            trace_status_out         <= pop_word[3:0];
         end
      end
   end

endmodule // debug_halt_and_trace_port

`default_nettype wire

// ===== testbench/dbg_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_trace_defines.svh"

module dbg_port_properties (
   input wire logic clk, reset_n, halt_request_in, halt_ack_out, core_run_enable,
   input wire logic core_wb_valid, core_wb_complete, wb_full_out, wb_complete_out,
   input wire logic [`WB_ADDR_W-1:0] core_wb_addr, wb_instr_addr_out,
   input wire logic core_set_we, wait_enable_out, uncond_event_in, uncond_event_flag,
   input wire logic internal_debug_mode_bit, external_debug_mode_bit, trigger_out,
   input wire logic [`TRIG_TYPE_UNCOND-1:0] core_debug_events,
   input wire logic [`TRIG_TYPE_W-1:0] trigger_type_out,
   input wire logic trace_cycle_strobe, bus_hold_ack_in, bus_held_out, debug_op_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ****************
   // Pin answers allow the four-edge synchroniser
   // ****************
   property p_halt_ack; halt_ack_out |-> !core_run_enable; endproperty
   a_halt_ack: assert property (p_halt_ack) else $error("run enable high while halted");
   property p_halt_req; halt_request_in [*8] |-> halt_ack_out; endproperty
   a_halt_req: assert property (p_halt_req) else $error("halt request not obeyed");
   property p_wb; core_wb_valid |=> wb_full_out && wb_instr_addr_out == $past(core_wb_addr);
   endproperty
   a_wb: assert property (p_wb) else $error("writeback full or address wrong");
   property p_wb_cpl;
      1'b1 |=> wb_complete_out == ($past(core_wb_valid) && $past(core_wb_complete));
   endproperty
   a_wb_cpl: assert property (p_wb_cpl) else $error("writeback complete wrong");
   property p_we; core_set_we |-> ##2 wait_enable_out; endproperty
   a_we: assert property (p_we) else $error("wait enable not shown");
   property p_trig_off; internal_debug_mode_bit || external_debug_mode_bit |=> !trigger_out;
   endproperty
   a_trig_off: assert property (p_trig_off) else $error("trigger in debug mode");
   property p_trig_type;
      !internal_debug_mode_bit && !external_debug_mode_bit && core_debug_events != 10'h000
         |=> trigger_out && trigger_type_out[9:0] == $past(core_debug_events);
   endproperty
   a_trig_type: assert property (p_trig_type) else $error("trigger type wrong");
   property p_uncond; uncond_event_in [*8] |-> uncond_event_flag; endproperty
   a_uncond: assert property (p_uncond) else $error("event flag not set");
   property p_strobe; trace_cycle_strobe |=> !trace_cycle_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("trace strobes too close");
   property p_hold; bus_hold_ack_in [*8] |-> bus_held_out && !debug_op_done; endproperty
   a_hold: assert property (p_hold) else $error("debug answer with bus held");
   c_halt: cover property (halt_ack_out);
   c_trig: cover property (trigger_out && trigger_type_out[10]);
   c_strobe: cover property (trace_cycle_strobe);
endmodule // dbg_port_properties

bind debug_halt_and_trace_port dbg_port_properties u_props (.*);

`default_nettype wire

// ===== testbench/trace_debug_partner.sv
`timescale 1ns/10ps
`default_nettype none

module trace_debug_partner (
   input  wire logic clk,              // Processor clock
   input  wire logic reset_n,          // Async reset, active low
   input  wire logic slow,             // Collector stalls half the time
   input  wire logic dbg_halt_n,       // Debugger halt, active low
   input  wire logic trigger_out,      // Trigger from the port
   output logic      trigger_in,       // Trigger returned
   output logic      halt_request_in,  // Halt to the port
   output logic      trace_sink_ready  // Collector takes a word
);
   logic [2:0] stall_q;

   // Unused trace: trigger wrapped straight back
   assign trigger_in = trigger_out;
   assign halt_request_in = !dbg_halt_n;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) stall_q <= 3'h0;
      else stall_q <= stall_q + 3'h1;
   end
   // Half duty over both phases, slower than the push rate
   assign trace_sink_ready = !slow || stall_q[2];
endmodule // trace_debug_partner

`default_nettype wire

// ===== testbench/debug_halt_and_trace_port_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_trace_defines.svh"

module debug_halt_and_trace_port_test;
   logic clk = 1'b0, reset_n = 1'b0;
   logic bus_hold_ack_in, halt_request_in, uncond_event_in, trigger_in, trace_disable_in;
   logic trace_sink_ready, core_wb_valid, core_wb_complete, core_set_we, core_ext_irq;
   logic core_timer_irq, dbg_clear_we, scan_stop_cmd, scan_resume_cmd, uncond_flag_clear;
   logic internal_debug_mode_bit, external_debug_mode_bit, debug_op_req, trace_overflow_clear;
   logic [`WB_ADDR_W-1:0] core_wb_addr, wb_instr_addr_out;
   logic [`TRIG_TYPE_UNCOND-1:0] core_debug_events;
   logic [`EXEC_STATUS_W-1:0] core_exec_status, first_cycle_exec_status, second_cycle_exec_status;
   logic [`TRACE_STATUS_W-1:0] core_trace_status, trace_status_out;
   logic [`TRIG_TYPE_W-1:0] trigger_type_out;
   logic wb_full_out, wb_complete_out, wait_enable_out, halt_ack_out, trigger_out;
   logic trace_cycle_strobe, core_run_enable, debug_irq_out, uncond_event_flag, bus_held_out;
   logic debug_op_done, trace_overflow_out, slow, dbg_halt_n, seen_irq, seen_trig;
   logic [31:0] wb_q[$];
   int fail_count = 0, n_compared = 0, marks = 0, strobes = 0, seed = 36365;

   // Never gated, so a raised halt always finds the clock running
   always #4 clk = ~clk;
   debug_halt_and_trace_port dut (.*);
   trace_debug_partner far_end (.clk(clk), .reset_n(reset_n), .slow(slow),
      .dbg_halt_n(dbg_halt_n), .trigger_out(trigger_out), .trigger_in(trigger_in),
      .halt_request_in(halt_request_in), .trace_sink_ready(trace_sink_ready));

   // ****************
   // Shared tasks
   // ****************
   task automatic check(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task complete_run();
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic await(string nm, ref logic s, input logic v);
      for (int i = 0; i < 40 && s !== v; i++) @(negedge clk);
      check(nm, v, s);
      if (s !== v) complete_run();
   endtask

   // Status held constant so every trace word is predictable
   always @(negedge clk) begin
      if (wb_full_out === 1'b1) begin
         if (wb_q.size() == 0) check("wb_full_out", 0, 1);
         else check("wb word", wb_q.pop_front(), {wb_complete_out, 1'b0, wb_instr_addr_out});
      end
      if (trace_cycle_strobe === 1'b1) begin
         strobes++;
         if (trace_status_out[3] === 1'b1) marks++;
         check("trace word", {core_exec_status, core_exec_status, core_trace_status[2:0]},
            {first_cycle_exec_status, second_cycle_exec_status, trace_status_out[2:0]});
      end
      if (debug_irq_out === 1'b1) seen_irq = 1'b1;
      if (trigger_out === 1'b1 && trigger_type_out[10] === 1'b1) seen_trig = 1'b1;
   end

   initial begin
      {bus_hold_ack_in, uncond_event_in, trace_disable_in, core_wb_valid, core_wb_complete} = '0;
      {core_set_we, core_ext_irq, core_timer_irq, dbg_clear_we, scan_stop_cmd} = '0;
      {scan_resume_cmd, uncond_flag_clear, internal_debug_mode_bit, external_debug_mode_bit} = '0;
      {debug_op_req, trace_overflow_clear, core_debug_events, core_wb_addr, slow} = '0;
      {seen_irq, seen_trig} = '0;
      dbg_halt_n = 1'b0;
      core_exec_status = 2'($random(seed));
      core_trace_status = {1'b0, 3'($random(seed))};
      cyc(3);
      reset_n = 1'b1;
      cyc(12);
      check("halt_ack_out", 1, halt_ack_out);
      check("core_run_enable", 0, core_run_enable);
      dbg_halt_n = 1'b1;
      await("core_run_enable", core_run_enable, 1'b1);
      await("halt_ack_out", halt_ack_out, 1'b0);
      for (int i = 0; i < 24; i++) begin
         core_wb_valid = 1'($random(seed));
         core_wb_complete = 1'($random(seed));
         core_wb_addr = 30'($random(seed));
         if (core_wb_valid) wb_q.push_back({core_wb_complete, 1'b0, core_wb_addr});
         cyc(1);
      end
      core_wb_valid = 1'b0;
      cyc(2);
      check("wb notes left", 0, wb_q.size());
      scan_stop_cmd = 1'b1;
      cyc(1);
      scan_stop_cmd = 1'b0;
      await("halt_ack_out", halt_ack_out, 1'b1);
      reset_n = 1'b0;
      cyc(2);
      reset_n = 1'b1;
      await("core_run_enable", core_run_enable, 1'b1);
      for (int m = 0; m < 3; m++) begin
         internal_debug_mode_bit = (m == 1);
         external_debug_mode_bit = (m == 2);
         {seen_irq, seen_trig} = '0;
         uncond_event_in = 1'b1;
         cyc(10);
         uncond_event_in = 1'b0;
         cyc(8);
         check("uncond_event_flag", 1, uncond_event_flag);
         check("debug irq seen", m == 1, seen_irq);
         check("uncond trigger seen", m == 0, seen_trig);
         check("halt_ack_out", m == 2, halt_ack_out);
         uncond_flag_clear = 1'b1;
         scan_resume_cmd = 1'b1;
         cyc(1);
         {uncond_flag_clear, scan_resume_cmd} = '0;
         await("uncond_event_flag", uncond_event_flag, 1'b0);
         await("core_run_enable", core_run_enable, 1'b1);
      end
      {internal_debug_mode_bit, external_debug_mode_bit} = '0;
      for (int k = 0; k < 3; k++) begin
         core_set_we = 1'b1;
         cyc(1);
         core_set_we = 1'b0;
         cyc(3);
         check("wait_enable_out", 1, wait_enable_out);
         check("core_run_enable", 0, core_run_enable);
         {core_ext_irq, core_timer_irq, dbg_clear_we} = 3'h4 >> k;
         cyc(1);
         {core_ext_irq, core_timer_irq, dbg_clear_we} = 3'h0;
         await("core_run_enable", core_run_enable, 1'b1);
         check("wait_enable_out", 0, wait_enable_out);
      end
      bus_hold_ack_in = 1'b1;
      cyc(8);
      debug_op_req = 1'b1;
      cyc(1);
      debug_op_req = 1'b0;
      cyc(10);
      check("bus_held_out", 1, bus_held_out);
      bus_hold_ack_in = 1'b0;
      await("debug_op_done", debug_op_done, 1'b1);
      marks = 0;
      // Wrapped trigger must outlast the pin filter
      core_debug_events = 10'h001;
      cyc(3);
      core_debug_events = 10'h000;
      cyc(20);
      check("trigger marks", 1, marks > 0);
      // Slow collector must overflow the buffer, never stall the core
      slow = 1'b1;
      cyc(300);
      check("trace_overflow_out", 1, trace_overflow_out);
      check("core_run_enable", 1, core_run_enable);
      strobes = 0;
      trace_disable_in = 1'b1;
      slow = 1'b0;
      cyc(8);
      trace_overflow_clear = 1'b1;
      cyc(1);
      trace_overflow_clear = 1'b0;
      cyc(100);
      check("drained after disable", 1, strobes >= 16);
      check("trace_overflow_out", 0, trace_overflow_out);
      strobes = 0;
      cyc(40);
      check("strobes while disabled", 0, strobes);
      complete_run();
   end
endmodule // debug_halt_and_trace_port_test

`default_nettype wire
